// ---- hdl/prog_ctrl_pkg.sv ----
package prog_ctrl_pkg;

  // System clock rate in kHz.
  localparam int unsigned SYS_CLK_KHZ = 40000;

  // Pin widths of the memory part.
  localparam int ADDR_W = 14;  // Width of address_lines.
  localparam int DATA_W = 8;   // Width of data_lines.

  // Program pulse width, nominal and bounds, in microseconds.
  localparam int unsigned PULSE_NOM_US = 100;
  localparam int unsigned PULSE_MIN_US = 95;
  localparam int unsigned PULSE_MAX_US = 105;
  // Nominal pulse lies inside the bounds, so the nominal count is used.
  localparam int unsigned PULSE_CYC = PULSE_NOM_US * SYS_CLK_KHZ / 1000;

  // Setup time for address, data, strobes and supply, in microseconds (least time).
  localparam int unsigned SETUP_US  = 2;
  localparam int unsigned SETUP_CYC = (SETUP_US * SYS_CLK_KHZ + 999) / 1000;

  // Data valid after output gate falls, in nanoseconds (longest wait, rounded up to be safe).
  localparam int unsigned OE_VALID_NS  = 130;
  localparam int unsigned OE_VALID_CYC = (OE_VALID_NS * SYS_CLK_KHZ + 999999) / 1000000;

  // Timer width and most pulses per byte.
  localparam int TMR_W = 13;
  localparam logic [3:0] MAX_PULSES = 4'ha;

  // Erased byte value.
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

  // Controller states, Gray coded along the programming path.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SETUP  = 4'h1,
    ST_PULSE  = 4'h3,
    ST_HOLD   = 4'h2,
    ST_VGATE  = 4'h6,
    ST_VCHECK = 4'h7,
    ST_DONE   = 4'h5,
    ST_READ   = 4'h4,
    ST_RCHECK = 4'hc
  } state_type;

  // Operation requested by the user side.
  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_IDENT   = 2'h2
  } op_type;

endpackage : prog_ctrl_pkg

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs; the first stage feeds only the second.
module pin_sync
  import prog_ctrl_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,  // System clock.
  input  wire logic             rst,      // Asynchronous reset, active high.
  input  wire logic [WIDTH-1:0] din,      // Asynchronous pin levels.
  output logic      [WIDTH-1:0] dout      // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second.

  // Both stages clear to zero at reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : pin_sync

// ---- hdl/prog_ctrl.sv ----
`timescale 1ns/1ps
module prog_ctrl
  import prog_ctrl_pkg::*;
(
  input  wire logic              sys_clk,          // System clock, 40 MHz.
  input  wire logic              rst,              // Asynchronous reset, active high.
  input  wire logic              req_valid,        // Request strobe, one cycle.
  input  wire op_type            req_op,           // Requested operation.
  input  wire logic [ADDR_W-1:0] req_addr,         // Target address.
  input  wire logic [DATA_W-1:0] req_data,         // Data to program.
  output logic                   busy,             // Operation in progress.
  output logic                   done,             // Completion pulse.
  output logic                   fail,             // Program failed, with done.
  output logic      [DATA_W-1:0] rd_data,          // Byte read or last verify byte.
  output logic      [3:0]        pulse_count,      // Pulses used on last byte.
  output logic      [ADDR_W-1:0] address_lines,    // Address pins.
  output logic      [DATA_W-1:0] data_lines_o,     // Data pin drive value.
  output logic      [DATA_W-1:0] data_lines_oe,    // Data pin enables, high drives.
  input  wire logic [DATA_W-1:0] data_lines_i,     // Data pin levels.
  output logic                   chip_select_n,    // Chip select, active low.
  output logic                   output_gate_n,    // Output gate, active low.
  output logic                   write_strobe_n,   // Write strobe, active low.
  output logic                   supply_elevated,  // Programming supply at elevated level.
  output logic                   identity_select_line  // Identity line at elevated level.
);

  state_type         state_q, state_d;   // Controller state.
  op_type            op_q;               // Latched operation.
  logic [TMR_W-1:0]  tmr_q;              // Phase timer.
  logic [DATA_W-1:0] want_q;             // Intended byte.
  logic [DATA_W-1:0] rd_sync;            // Synchronised data pins.
  logic              tmr_zero;           // Timer expired.
  logic              match;              // Read byte equals intended byte.
  logic              at_limit;           // Pulse limit reached.
  logic              accept;             // Request taken at this edge.
  op_type            op_d;               // Operation in force from this edge on.
  logic [DATA_W-1:0] want_d;             // Intended byte in force from this edge on.

  // Data pins come from outside the clock domain, so they are synchronised.
  pin_sync #(.WIDTH(DATA_W)) u_data_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (data_lines_i),
    .dout    (rd_sync)
  );

  // Verify compares the whole byte, so untouched ones are checked too.
  assign tmr_zero = (tmr_q == '0);
  assign match    = (rd_sync == want_q);
  assign at_limit = (pulse_count == MAX_PULSES);

  // The pin registers load at the accept edge, while op_q and want_q are only
  // being loaded there. Looking at the old values would leave the previous
  // operation's supply or identity level on the pins for one cycle, and would
  // drive the previous byte in the first setup cycle, cutting data setup short.
  assign accept = (state_q == ST_IDLE) && req_valid;
  assign op_d   = accept ? req_op : op_q;
  assign want_d = accept ? req_data : want_q;

  // Next-state decoding.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          state_d = (req_op == OP_PROGRAM) ? ST_SETUP : ST_READ;
        end
      end
      ST_SETUP: begin
        // Address, data and supply settle before the strobe falls.
        if (tmr_zero) begin
          state_d = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tmr_zero) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_zero) begin
          state_d = ST_VGATE;
        end
      end
      ST_VGATE: begin
        if (tmr_zero) begin
          state_d = ST_VCHECK;
        end
      end
      ST_VCHECK: begin
        // Stop on first match; otherwise pulse again until the limit.
        if (match || at_limit) begin
          state_d = ST_DONE;
        end else begin
          state_d = ST_SETUP;
        end
      end
      ST_READ: begin
        if (tmr_zero) begin
          state_d = ST_RCHECK;
        end
      end
      ST_RCHECK: state_d = ST_DONE;
      ST_DONE:   state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Phase timer, loaded on each state entry.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmr_q <= '0;
    end else if (state_d != state_q) begin
      unique case (state_d)
        ST_PULSE: tmr_q <= TMR_W'(PULSE_CYC - 1);
        ST_READ:  tmr_q <= TMR_W'(SETUP_CYC + OE_VALID_CYC + 2);
        ST_VGATE: tmr_q <= TMR_W'(OE_VALID_CYC + 2);
        default:  tmr_q <= TMR_W'(SETUP_CYC - 1);
      endcase
    end else if (!tmr_zero) begin
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // Request capture; a request while busy is ignored.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_q          <= OP_READ;
      want_q        <= ERASED_BYTE;
      address_lines <= '0;
    end else if (state_q == ST_IDLE && req_valid) begin
      op_q          <= req_op;
      want_q        <= req_data;
      address_lines <= req_addr;
    end
  end

  // Pulse counter, counting strobe pulses on the current byte.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_count <= '0;
    end else if (state_q == ST_IDLE && req_valid) begin
      pulse_count <= '0;
    end else if (state_q == ST_SETUP && state_d == ST_PULSE) begin
      pulse_count <= pulse_count + 1'b1;
    end
  end

  // Pin drive. Only one part is driven, so a single select suffices; parallel
  // parts would need one select per part.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chip_select_n        <= 1'b1;
      output_gate_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      supply_elevated      <= 1'b0;
      identity_select_line <= 1'b0;
      data_lines_o         <= ERASED_BYTE;
      data_lines_oe        <= '0;
    end else begin
      chip_select_n        <= (state_d == ST_IDLE) || (state_d == ST_DONE);
      supply_elevated      <= (op_d == OP_PROGRAM) && (state_d != ST_IDLE);
      identity_select_line <= (op_d == OP_IDENT) && (state_d == ST_READ ||
                                                     state_d == ST_RCHECK);
      // Gate low only while reading or verifying, so the part drives then.
      output_gate_n  <= !(state_d == ST_READ || state_d == ST_RCHECK ||
                          state_d == ST_VGATE || state_d == ST_VCHECK);
      write_strobe_n <= (state_d != ST_PULSE);
      // Host drives data only in program phases, with the gate high.
      data_lines_o   <= want_d;
      data_lines_oe  <= {DATA_W{state_d == ST_SETUP || state_d == ST_PULSE ||
                                state_d == ST_HOLD}};
    end
  end

  // Status outputs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      fail    <= 1'b0;
      rd_data <= ERASED_BYTE;
    end else begin
      busy <= (state_d != ST_IDLE);
      done <= (state_d == ST_DONE);
      if (state_q == ST_VCHECK || state_q == ST_RCHECK) begin
        rd_data <= rd_sync;
      end
      if (state_q == ST_VCHECK && state_d == ST_DONE) begin
        fail <= !match;
      end else if (state_q == ST_RCHECK) begin
        fail <= 1'b0;
      end else if (state_d == ST_IDLE) begin
        // The flag stands with done only and drops once the block is idle.
        fail <= 1'b0;
      end
    end
  end

endmodule : prog_ctrl

// ---- sim/prog_ctrl_asserts.sv ----
`timescale 1ns/1ps
// Pin-level checks on the controller, bound to its ports.
module prog_ctrl_asserts
  import prog_ctrl_pkg::*;
(
  input wire logic              sys_clk,              // Clock.
  input wire logic              rst,                  // Reset.
  input wire logic              req_valid,            // Request.
  input wire op_type            req_op,               // Operation.
  input wire logic              busy,                 // Busy.
  input wire logic              done,                 // Done.
  input wire logic              fail,                 // Fail.
  input wire logic [3:0]        pulse_count,          // Pulses used.
  input wire logic [ADDR_W-1:0] address_lines,        // Address pins.
  input wire logic [DATA_W-1:0] data_lines_o,         // Data drive.
  input wire logic [DATA_W-1:0] data_lines_oe,        // Data enables.
  input wire logic              chip_select_n,        // Select.
  input wire logic              output_gate_n,        // Gate.
  input wire logic              write_strobe_n,       // Strobe.
  input wire logic              supply_elevated,      // Supply high.
  input wire logic              identity_select_line  // Identity line.
);
  logic [12:0] low_q;    // Cycles the strobe has been low.
  logic [3:0]  falls_q;  // Pulses in the current operation.
  // Counters are cleared by reset so no stale count leaks into a new run.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_q   <= '0;
      falls_q <= '0;
    end else begin
      low_q   <= write_strobe_n ? 13'h0 : low_q + 13'h1;
      falls_q <= done ? 4'h0 : falls_q + {3'h0, !write_strobe_n && low_q == 13'h0};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_read_take;
    req_valid && !busy && req_op == OP_READ;
  endsequence
  sequence s_read_pins;
    (!chip_select_n && !output_gate_n && write_strobe_n && !supply_elevated) [*8];
  endsequence
  // A read waits the setup and data valid counts plus sync margin, so done
  // comes 91 cycles after the accept edge.
  a_read_walk: assert property (s_read_take |-> ##1 s_read_pins ##83 done)
    else $error("Read cycle pins or timing wrong.");
  a_idle_standby: assert property (!busy |-> chip_select_n && write_strobe_n)
    else $error("Part not in standby while idle.");
  a_no_contention: assert property (!output_gate_n |-> data_lines_oe == 8'h00)
    else $error("Host drives data while gate is low.");
  a_strobe_setup: assert property ($fell(write_strobe_n) |-> $stable(address_lines)
    && $stable(data_lines_o) && data_lines_oe == 8'hff)
    else $error("Address or data moved at strobe fall.");
  a_strobe_mode: assert property (!write_strobe_n |->
    !chip_select_n && output_gate_n && supply_elevated)
    else $error("Strobe low outside program mode.");
  a_pulse_width: assert property ($rose(write_strobe_n) |->
    low_q >= 13'hed8 && low_q <= 13'h1068)
    else $error("Strobe pulse width out of bounds.");
  a_verify_follows: assert property ($rose(write_strobe_n) |->
    ##[1:200] (!output_gate_n && supply_elevated && write_strobe_n))
    else $error("No verify read after a pulse.");
  a_pulse_limit: assert property (done |-> falls_q <= 4'ha
    && (falls_q == 4'h0 || pulse_count == falls_q))
    else $error("Pulse count wrong or over limit.");
  a_fail_limit: assert property (done && fail |-> falls_q == 4'ha)
    else $error("Failure flagged before the pulse limit.");
  a_ident_mode: assert property ($rose(identity_select_line) |->
    !chip_select_n && !output_gate_n && !supply_elevated)
    else $error("Identity line raised outside identity read.");
endmodule : prog_ctrl_asserts

bind prog_ctrl prog_ctrl_asserts u_asserts (.sys_clk, .rst, .req_valid, .req_op, .busy,
  .done, .fail, .pulse_count, .address_lines, .data_lines_o, .data_lines_oe, .chip_select_n,
  .output_gate_n, .write_strobe_n, .supply_elevated, .identity_select_line);

// ---- sim/eprom_model.sv ----
`timescale 1ns/1ps
// Behavioural memory part: array, mode decode and identity bytes.
module eprom_model
  import prog_ctrl_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value.
  parameter logic [7:0] TYPE_CODE  = 8'hc3   // Arbitrary value.
) (
  input  wire logic [ADDR_W-1:0] address_lines,         // Address pins.
  input  wire logic [DATA_W-1:0] data_lines,            // Resolved data pins.
  input  wire logic              chip_select_n,         // Select, active low.
  input  wire logic              output_gate_n,         // Gate, active low.
  input  wire logic              write_strobe_n,        // Strobe, active low.
  input  wire logic              supply_elevated,       // Supply elevated.
  input  wire logic              identity_select_line,  // Identity line elevated.
  output logic      [DATA_W-1:0] dev_q,                 // Value the part drives.
  output logic                   dev_en                 // High while the part drives.
);
  logic [DATA_W-1:0] mem [2**ADDR_W];  // Array.
  // A blank part reads all ones.
  initial begin
    foreach (mem[i])
      mem[i] = ERASED_BYTE;
  end
  // The byte is written as the pulse ends; ones leave stored bits alone.
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && output_gate_n && supply_elevated) begin
      mem[address_lines] <= mem[address_lines] & data_lines;
    end
  end
  // Drives only in read, verify and identity modes; floats otherwise.
  assign dev_en = !chip_select_n && !output_gate_n && write_strobe_n;
  assign dev_q  = (identity_select_line && !supply_elevated)
                  ? (address_lines[0] ? TYPE_CODE : MAKER_CODE)
                  : mem[address_lines];
endmodule : eprom_model

// ---- sim/prog_ctrl_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module prog_ctrl_tb
  import prog_ctrl_pkg::*;
;
  logic sys_clk, rst, req_valid, busy, done, fail, dev_en;
  logic chip_select_n, output_gate_n, write_strobe_n, supply_elevated, identity_select_line;
  op_type req_op;
  logic [ADDR_W-1:0] req_addr, address_lines;
  logic [DATA_W-1:0] req_data, rd_data, data_lines_o, data_lines_oe, pins, dev_q;
  logic [DATA_W-1:0] idle_q = 8'h3c;  // Undriven bus pattern, changes every cycle.
  logic [3:0] pulse_count;
  int num_errors = 0;
  int checks_done = 0;
  prog_ctrl dut (.sys_clk, .rst, .req_valid, .req_op, .req_addr, .req_data, .busy, .done,
    .fail, .rd_data, .pulse_count, .address_lines, .data_lines_o, .data_lines_oe,
    .data_lines_i(pins), .chip_select_n, .output_gate_n, .write_strobe_n, .supply_elevated,
    .identity_select_line);
  eprom_model u_part (.address_lines, .data_lines(pins), .chip_select_n, .output_gate_n,
    .write_strobe_n, .supply_elevated, .identity_select_line, .dev_q, .dev_en);
  // Released bus never holds its last value, so a late sample is seen.
  assign pins = (data_lines_oe & data_lines_o) | (~data_lines_oe & (dev_en ? dev_q : idle_q));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) idle_q <= ~idle_q;
  // One request, then wait for completion and judge the outcome.
  task automatic run(input op_type op, input logic [13:0] a, input logic [7:0] d,
                     input logic [7:0] exp, input logic exp_fail, input logic [3:0] pc);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    req_data  <= d;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (int n = 0; n < 50000 && done !== 1'b1; n++) @(negedge sys_clk);
    `CHK(done, 1'b1)
    `CHK(rd_data, exp)
    `CHK(fail, exp_fail)
    if (op == OP_PROGRAM) `CHK(pulse_count, pc)
  endtask : run
  task automatic t_idle();
    `CHK(chip_select_n, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(rd_data, ERASED_BYTE)
    $display("Test idle finished");
  endtask : t_idle
  task automatic t_ident();
    run(OP_IDENT, 14'h0000, 8'h00, 8'h5a, 1'b0, 4'h0);
    run(OP_IDENT, 14'h0001, 8'h00, 8'hc3, 1'b0, 4'h0);
    $display("Test identity finished");
  endtask : t_ident
  task automatic t_program();
    run(OP_READ, 14'h3fff, 8'h00, 8'hff, 1'b0, 4'h0);
    run(OP_PROGRAM, 14'h0123, 8'ha5, 8'ha5, 1'b0, 4'h1);
    run(OP_READ, 14'h0123, 8'h00, 8'ha5, 1'b0, 4'h0);
    $display("Test program finished");
  endtask : t_program
  // Ones cannot be restored, so verify never matches and the limit is hit.
  task automatic t_fail();
    run(OP_PROGRAM, 14'h0123, 8'h5a, 8'h00, 1'b1, 4'ha);
    run(OP_READ, 14'h0123, 8'h00, 8'h00, 1'b0, 4'h0);
    $display("Test fail finished");
  endtask : t_fail
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // Watchdog: the longest run is about 1.04 ms of programming.
  initial begin
    #2000000;
    num_errors++;
    results();
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = OP_READ;
    req_addr = '0;
    req_data = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    t_idle();
    t_ident();
    t_program();
    t_fail();
    results();
  end
endmodule : prog_ctrl_tb
